// file: inc/transceiver_mode_pkg.sv
`default_nettype none
package transceiver_mode_pkg;

	// Datapath geometry
	localparam int CH_NUM = 8;
	localparam int WORD_W = 10;

	// Register map, byte addresses on the bus
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_FLAGS = 8'h08;

	// Control register fields
	localparam int CTRL_CODING_POS = 7;
	localparam int CTRL_VFORCE_POS = 14;
	localparam int CTRL_TCLK_POS = 15;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_C080;

	// Status register fields
	localparam int ST_CODING_POS = 0;
	localparam int ST_VFORCE_POS = 1;
	localparam int ST_SERIAL_LOOPBACK_POS = 2;
	localparam int ST_MODE_LSB = 3;
	localparam int ST_INDEP_POS = 5;
	localparam int ST_BUSY_POS = 6;
	localparam int ST_LOCK_POS = 7;
	localparam int ST_ENABLE_POS = 8;
	localparam int ST_ADDR_LSB = 16;

	// Sticky flag register fields
	localparam int FL_RSVD_MODE_POS = 8;
	localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;

	// Forced receive word on a coding fault
	localparam logic [9:0] VIOLATION_WORD = 10'h3FF;

	// Lock wait after power-up or power-down
	localparam int LOCK_TIME_US = 100;
	localparam int CLK_MHZ = 125;
	localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;

	// Test port instruction register
	localparam logic [1:0] IR_CAPTURE = 2'h1;
	localparam logic [1:0] IR_BYPASS = 2'h3;

	// Parallel interface selection
	typedef enum logic [1:0] {
		IF_MUXED = 2'b00,
		IF_RSVD_A = 2'b01,
		IF_NIBBLE = 2'b10,
		IF_RSVD_B = 2'b11
	} if_mode_t;

	// Test access port controller states
	typedef enum logic [3:0] {
		TAP_RESET = 4'b0000,
		TAP_IDLE = 4'b0001,
		TAP_SEL_DR = 4'b0010,
		TAP_CAP_DR = 4'b0011,
		TAP_SH_DR = 4'b0100,
		TAP_EX1_DR = 4'b0101,
		TAP_PA_DR = 4'b0110,
		TAP_EX2_DR = 4'b0111,
		TAP_UPD_DR = 4'b1000,
		TAP_SEL_IR = 4'b1001,
		TAP_CAP_IR = 4'b1010,
		TAP_SH_IR = 4'b1011,
		TAP_EX1_IR = 4'b1100,
		TAP_PA_IR = 4'b1101,
		TAP_EX2_IR = 4'b1110,
		TAP_UPD_IR = 4'b1111
	} tap_state_t;

	// Static configuration pins
	typedef struct packed {
		logic coding_pin;
		logic violation_force_pin;
		logic serial_loopback;
		logic [1:0] mode;
		logic device_enable;
		logic transfer_clock_select;
		logic busy_pass_enable;
		logic chip_reset;
		logic power_down;
		logic [4:0] mgmt_phys_address_strap;
	} cfg_pins_t;

	// Boundary-scan port pins
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic trst_n;
	} jtag_pins_t;

endpackage
`default_nettype wire

// file: logic/transceiver_mode_control.sv
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module transceiver_mode_control
	import transceiver_mode_pkg::*;
#(
	parameter int unsigned LOCK_WAIT = LOCK_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire cfg_pins_t cfg_pins,
	input wire jtag_pins_t jtag_pins,
	input wire logic [CH_NUM-1:0][WORD_W-1:0] enc_word_in,
	input wire logic [CH_NUM-1:0][WORD_W-1:0] ser_word_in,
	input wire logic [CH_NUM-1:0][WORD_W-1:0] dec_word_in,
	input wire logic [CH_NUM-1:0] dec_fault_in,
	output logic [CH_NUM-1:0][WORD_W-1:0] dec_feed_out,
	output logic [CH_NUM-1:0][WORD_W-1:0] ser_tx_out,
	output logic ser_tx_oe,
	output logic [CH_NUM-1:0][WORD_W-1:0] receive_word_out,
	output logic par_oe,
	output logic coding_enable,
	output logic violation_force,
	output logic serial_loopback,
	output if_mode_t interface_mode,
	output logic independent_clock_mode,
	output logic idle_delete_enable,
	output logic skew_recenter,
	output logic fifo_recenter,
	output logic [4:0] mgmt_phys_address,
	output logic pll_lock,
	output logic tdo,
	output logic tdo_oe
);

	// Test port next state from TMS
	function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
		tap_state_t n;
		n = s;
		unique case (s)
			TAP_RESET: n = m ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: n = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: n = m ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: n = m ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR: n = m ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: n = m ? TAP_UPD_DR : TAP_PA_DR;
			TAP_PA_DR: n = m ? TAP_EX2_DR : TAP_PA_DR;
			TAP_EX2_DR: n = m ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR: n = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: n = m ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: n = m ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR: n = m ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: n = m ? TAP_UPD_IR : TAP_PA_IR;
			TAP_PA_IR: n = m ? TAP_EX2_IR : TAP_PA_IR;
			TAP_EX2_IR: n = m ? TAP_UPD_IR : TAP_SH_IR;
			TAP_UPD_IR: n = m ? TAP_SEL_DR : TAP_IDLE;
		endcase
		return n;
	endfunction

	// Pin synchronisers, first stage read only by second
	cfg_pins_t cfg_meta_q; // First stage
	cfg_pins_t cfg_q; // Safe copy of the pins
	jtag_pins_t jtag_meta_q; // First stage
	jtag_pins_t jtag_q; // Safe copy of the test pins
	logic tck_prev_q; // Previous test clock level
	logic chip_reset_prev_q; // Previous chip reset level

	// Register file
	logic [31:0] ctrl_q; // Software control bits
	logic [31:0] flags_q; // Sticky fault flags
	logic wr_pend_q; // Write data phase due
	logic [ADDR_W-1:0] wr_addr_q; // Address of that write

	// Lock timer
	logic [31:0] lock_cnt_q;

	// Test port
	tap_state_t tap_q;
	logic [1:0] ir_q; // Active instruction
	logic [1:0] ir_sr_q; // Instruction shift stage
	logic bypass_q; // One-bit data register

	// Combined settings from pins and bits
	logic coding_eff;
	logic vforce_eff;
	logic tclk_eff;
	logic tck_rise;
	logic tck_fall;
	logic addr_valid;
	logic flag_clear;
	logic [31:0] flag_set;
	logic [31:0] status_word;

	// Both pin and bit may switch coding on
	assign coding_eff = cfg_q.coding_pin | ctrl_q[CTRL_CODING_POS];
	// Forcing needs its own enable and coding on
	assign vforce_eff = (cfg_q.violation_force_pin | ctrl_q[CTRL_VFORCE_POS]) & coding_eff;
	// Independent clocking wins if either source asks
	assign tclk_eff = cfg_q.transfer_clock_select | ctrl_q[CTRL_TCLK_POS];
	// Edges from the synchronised copy only
	assign tck_rise = jtag_q.tck & ~tck_prev_q;
	assign tck_fall = ~jtag_q.tck & tck_prev_q;
	// Single transfer accepted in address phase
	assign addr_valid = hsel & hready & htrans[1];
	assign flag_clear = wr_pend_q && (wr_addr_q == ADDR_FLAGS);

	// Sticky events: faults per channel and reserved mode
	always_comb begin
		flag_set = '0;
		flag_set[CH_NUM-1:0] = dec_fault_in & {CH_NUM{coding_eff}};
		flag_set[FL_RSVD_MODE_POS] = cfg_q.mode[0];
	end

	// Readable view of the live settings
	always_comb begin
		status_word = '0;
		status_word[ST_CODING_POS] = coding_eff;
		status_word[ST_VFORCE_POS] = vforce_eff;
		status_word[ST_SERIAL_LOOPBACK_POS] = cfg_q.serial_loopback;
		status_word[ST_MODE_LSB +: 2] = cfg_q.mode;
		status_word[ST_INDEP_POS] = tclk_eff;
		status_word[ST_BUSY_POS] = cfg_q.busy_pass_enable;
		status_word[ST_LOCK_POS] = pll_lock;
		status_word[ST_ENABLE_POS] = cfg_q.device_enable;
		status_word[ST_ADDR_LSB +: 5] = mgmt_phys_address;
	end

	// Two-stage capture of every static pin
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_meta_q <= '0;
			cfg_q <= '0;
			chip_reset_prev_q <= 1'b0;
		end else begin
			cfg_meta_q <= cfg_pins;
			cfg_q <= cfg_meta_q;
			chip_reset_prev_q <= cfg_q.chip_reset;
		end
	end

	// Test pin copies reset to zero, trst_n included
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			jtag_meta_q <= '0;
			jtag_q <= '0;
			tck_prev_q <= 1'b0;
		end else begin
			jtag_meta_q <= jtag_pins;
			jtag_q <= jtag_meta_q;
			tck_prev_q <= jtag_q.tck;
		end
	end

	// Bus slave: zero wait, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			hrdata <= '0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_q <= addr_valid & hwrite;
			if (addr_valid) begin
				wr_addr_q <= haddr[ADDR_W-1:0];
			end
			// Read data fetched in the address phase
			if (addr_valid && !hwrite) begin
				unique case (haddr[ADDR_W-1:0])
					ADDR_CTRL: hrdata <= ctrl_q;
					ADDR_STATUS: hrdata <= status_word;
					ADDR_FLAGS: hrdata <= flags_q;
					default: hrdata <= '0; // Unmapped reads zero
				endcase
			end
		end
	end

	// Control bits written in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= CTRL_RESET;
		end else if (wr_pend_q && wr_addr_q == ADDR_CTRL) begin
			ctrl_q <= hwdata & CTRL_WMASK;
		end
	end

	// Flags: chip reset or write-one clears, new event wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_q <= FLAGS_RESET;
		end else if (cfg_q.chip_reset) begin
			flags_q <= flag_set;
		end else if (flag_clear) begin
			flags_q <= (flags_q & ~hwdata) | flag_set;
		end else begin
			flags_q <= flags_q | flag_set;
		end
	end

	// Recenter commands follow the chip reset level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			skew_recenter <= 1'b0;
			fifo_recenter <= 1'b0;
		end else begin
			skew_recenter <= cfg_q.chip_reset;
			fifo_recenter <= cfg_q.chip_reset;
		end
	end

	// Strap address held from one reset rise to the next
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mgmt_phys_address <= '0;
		end else if (cfg_q.chip_reset && !chip_reset_prev_q) begin
			mgmt_phys_address <= cfg_q.mgmt_phys_address_strap;
		end
	end

	// Registered mode outputs for the datapath
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			coding_enable <= 1'b0;
			violation_force <= 1'b0;
			serial_loopback <= 1'b0;
			interface_mode <= IF_MUXED;
			independent_clock_mode <= 1'b0;
			idle_delete_enable <= 1'b1;
			par_oe <= 1'b0;
		end else begin
			coding_enable <= coding_eff;
			violation_force <= vforce_eff;
			serial_loopback <= cfg_q.serial_loopback;
			// Reserved codes pass through, flagged only
			interface_mode <= if_mode_t'(cfg_q.mode);
			// One: own clocks; zero: shared clocks
			independent_clock_mode <= tclk_eff;
			// Busy pair kept as data while busy is on
			idle_delete_enable <= ~cfg_q.busy_pass_enable;
			par_oe <= cfg_q.device_enable;
		end
	end

	// Channel paths: loopback mux, transmit, forcing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dec_feed_out <= '0;
			ser_tx_out <= '0;
			ser_tx_oe <= 1'b0;
			receive_word_out <= '0;
		end else begin
			// Serial input ignored during loopback
			dec_feed_out <= cfg_q.serial_loopback ? enc_word_in : ser_word_in;
			ser_tx_out <= enc_word_in;
			// Loopback floats the line even when enabled
			ser_tx_oe <= cfg_q.device_enable & ~cfg_q.serial_loopback;
			for (int c = 0; c < CH_NUM; c++) begin
				if (vforce_eff && dec_fault_in[c]) begin
					receive_word_out[c] <= VIOLATION_WORD;
				end else begin
					receive_word_out[c] <= dec_word_in[c];
				end
			end
		end
	end

	// Lock wait restarts on power-down; no real PLL sensing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_cnt_q <= '0;
			pll_lock <= 1'b0;
		end else if (cfg_q.power_down) begin
			lock_cnt_q <= '0;
			pll_lock <= 1'b0;
		end else if (lock_cnt_q >= 32'(LOCK_WAIT) - 32'h1) begin
			pll_lock <= 1'b1;
		end else begin
			lock_cnt_q <= lock_cnt_q + 32'h1;
		end
	end

	// Test port controller, stepped on sampled TCK rises
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tap_q <= TAP_RESET;
		end else if (!jtag_q.trst_n) begin
			tap_q <= TAP_RESET;
		end else if (tck_rise) begin
			tap_q <= tap_next(tap_q, jtag_q.tms);
		end
	end

	// Instruction and bypass registers shift on TCK rise
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ir_q <= IR_BYPASS;
			ir_sr_q <= IR_CAPTURE;
			bypass_q <= 1'b0;
		end else if (!jtag_q.trst_n || tap_q == TAP_RESET) begin
			ir_q <= IR_BYPASS;
			ir_sr_q <= IR_CAPTURE;
			bypass_q <= 1'b0;
		end else if (tck_rise) begin
			unique case (tap_q)
				TAP_CAP_IR: ir_sr_q <= IR_CAPTURE;
				TAP_SH_IR: ir_sr_q <= {jtag_q.tdi, ir_sr_q[1]};
				TAP_UPD_IR: ir_q <= ir_sr_q;
				TAP_CAP_DR: bypass_q <= 1'b0;
				TAP_SH_DR: bypass_q <= jtag_q.tdi;
				default: begin
				end
			endcase
		end
	end

	// TDO changes on TCK fall, driven only while shifting
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else if (!jtag_q.trst_n) begin
			tdo_oe <= 1'b0;
		end else if (tck_fall) begin
			// Every instruction selects bypass here
			tdo <= (tap_q == TAP_SH_IR) ? ir_sr_q[0] : bypass_q;
			tdo_oe <= cfg_q.device_enable & (tap_q == TAP_SH_IR || tap_q == TAP_SH_DR);
		end
	end

endmodule
`default_nettype wire

// file: verif/transceiver_mode_sva.sv
`timescale 1ns/1ps
`default_nettype none
module transceiver_mode_sva
	import transceiver_mode_pkg::*;
#(
	parameter int unsigned LOCK_WAIT = LOCK_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire cfg_pins_t cfg_pins,
	input wire jtag_pins_t jtag_pins,
	input wire logic [CH_NUM-1:0][WORD_W-1:0] enc_word_in,
	input wire logic [CH_NUM-1:0][WORD_W-1:0] dec_word_in,
	input wire logic [CH_NUM-1:0] dec_fault_in,
	input wire logic [CH_NUM-1:0][WORD_W-1:0] dec_feed_out,
	input wire logic [CH_NUM-1:0][WORD_W-1:0] receive_word_out,
	input wire logic ser_tx_oe,
	input wire logic par_oe,
	input wire logic coding_enable,
	input wire logic violation_force,
	input wire logic serial_loopback,
	input wire logic skew_recenter,
	input wire logic fifo_recenter,
	input wire logic pll_lock,
	input wire logic tdo_oe
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// Delayed power-down copies, mask the lock drop while it settles
	logic [1:0] pd_q;
	// Cycles since reset or power-down, saturating
	int unsigned lock_cnt_q;
	logic pd_any;
	assign pd_any = cfg_pins.power_down | (|pd_q);
	// Own lock timer, so a design that skips the wait is caught
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pd_q <= 2'h0;
			lock_cnt_q <= 0;
		end else begin
			pd_q <= {pd_q[0], cfg_pins.power_down};
			if (pd_any) begin
				lock_cnt_q <= 0;
			end else if (lock_cnt_q < LOCK_WAIT + 16) begin
				lock_cnt_q <= lock_cnt_q + 1;
			end
		end
	end
	property p_force;
		(violation_force && dec_fault_in[3]) ##1 violation_force |-> receive_word_out[3] == VIOLATION_WORD;
	endproperty
	a_force: assert property (p_force) else $error("no forced word on fault");
	property p_pass;
		!violation_force ##1 !violation_force |-> receive_word_out[3] == $past(dec_word_in[3]);
	endproperty
	a_pass: assert property (p_pass) else $error("word not passed");
	property p_gate;
		violation_force |-> coding_enable;
	endproperty
	a_gate: assert property (p_gate) else $error("forcing without coding");
	property p_loop;
		serial_loopback ##1 serial_loopback |-> dec_feed_out[0] == $past(enc_word_in[0]);
	endproperty
	a_loop: assert property (p_loop) else $error("loopback feed wrong");
	property p_float;
		serial_loopback && $past(serial_loopback) |-> !ser_tx_oe;
	endproperty
	a_float: assert property (p_float) else $error("serial out driven in loopback");
	property p_off;
		!par_oe && $past(!par_oe) |-> !ser_tx_oe;
	endproperty
	a_off: assert property (p_off) else $error("output driven while disabled");
	property p_center;
		cfg_pins.chip_reset [*4] |-> skew_recenter && fifo_recenter;
	endproperty
	a_center: assert property (p_center) else $error("no recenter in chip reset");
	property p_trst;
		!jtag_pins.trst_n [*4] |-> !tdo_oe;
	endproperty
	a_trst: assert property (p_trst) else $error("test output on in test reset");
	property p_lock;
		pll_lock && !pd_any |-> lock_cnt_q + 3 >= LOCK_WAIT;
	endproperty
	a_lock: assert property (p_lock) else $error("lock before wait");
	c_force: cover property (violation_force && dec_fault_in[3]);
	c_loop: cover property (serial_loopback);
	c_lock: cover property ($rose(pll_lock));
endmodule
bind transceiver_mode_control transceiver_mode_sva #(.LOCK_WAIT(LOCK_WAIT)) u_sva (.hclk, .hresetn,
	.cfg_pins, .jtag_pins, .enc_word_in, .dec_word_in, .dec_fault_in, .dec_feed_out, .receive_word_out,
	.ser_tx_oe, .par_oe, .coding_enable, .violation_force, .serial_loopback, .skew_recenter,
	.fifo_recenter, .pll_lock, .tdo_oe);
`default_nettype wire

// file: verif/pin_strap_model.sv
`timescale 1ns/1ps
`default_nettype none
module pin_strap_model
	import transceiver_mode_pkg::*;
(
	input wire logic hclk,
	input wire cfg_pins_t want,
	output var cfg_pins_t cfg_pins
);
	// Last loopback level, to spot a switch
	logic serial_loopback_q;
	// Pins move just after the edge, like a board controller
	always_ff @(posedge hclk) begin
		serial_loopback_q <= want.serial_loopback;
		cfg_pins <= want;
		// Channel reset pulse on every loopback switch
		if (want.serial_loopback != serial_loopback_q) begin
			cfg_pins.chip_reset <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// file: verif/test_transceiver_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_transceiver_mode_control
	import transceiver_mode_pkg::*;
;
	localparam int LW = 8;
	// Status after relock: busy on, locked, enabled, strap address 15
	localparam logic [31:0] ST_EXP = (32'h1 << ST_BUSY_POS) | (32'h1 << ST_LOCK_POS) |
		(32'h1 << ST_ENABLE_POS) | (32'h15 << ST_ADDR_LSB);
	logic hclk = 1'b0;
	logic hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic ser_tx_oe, par_oe, coding_enable, violation_force, serial_loopback, independent_clock_mode;
	logic idle_delete_enable, skew_recenter, fifo_recenter, pll_lock, tdo, tdo_oe;
	logic [CH_NUM-1:0][WORD_W-1:0] enc_word_in, ser_word_in, dec_word_in, dec_feed_out, ser_tx_out;
	logic [CH_NUM-1:0][WORD_W-1:0] receive_word_out;
	logic [CH_NUM-1:0] dec_fault_in;
	if_mode_t interface_mode;
	logic [4:0] mgmt_phys_address;
	cfg_pins_t want, cfg_pins;
	jtag_pins_t jtag_pins;
	int errors = 0;
	int num_checks = 0;
	int cycles = 0;
	// Row: control word, pins {coding, force, clock}, outputs {coding, force, independent}
	typedef struct packed {logic [31:0] ctrl; logic [2:0] pin; logic [2:0] exp;} row_t;
	row_t rows [10] = '{'{32'h0, 3'h0, 3'h0}, '{32'h0, 3'h4, 3'h4}, '{32'h80, 3'h0, 3'h4},
		'{32'h4000, 3'h0, 3'h0}, '{32'h4080, 3'h0, 3'h6}, '{32'h0, 3'h6, 3'h6}, '{32'h0, 3'h2, 3'h0},
		'{32'h8000, 3'h0, 3'h1}, '{32'h0, 3'h1, 3'h1}, '{32'hFFFFFFFF, 3'h0, 3'h7}};
	assign hready = hreadyout;
	always #4 hclk = ~hclk;
	pin_strap_model u_pins (.hclk, .want, .cfg_pins);
	transceiver_mode_control #(.LOCK_WAIT(LW)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .cfg_pins, .jtag_pins, .enc_word_in,
		.ser_word_in, .dec_word_in, .dec_fault_in, .dec_feed_out, .ser_tx_out, .ser_tx_oe,
		.receive_word_out, .par_oe, .coding_enable, .violation_force, .serial_loopback, .interface_mode,
		.independent_clock_mode, .idle_delete_enable, .skew_recenter, .fifo_recenter,
		.mgmt_phys_address, .pll_lock, .tdo, .tdo_oe);
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic wrap_up;
		if (errors == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// One single transfer; entered just after a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	// Idle cycle first, so a prior write has landed
	task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] rd;
		@(posedge hclk);
		bus(1'b0, a, 32'h0, rd);
		chk(n, e, rd);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	// One test clock period, long enough for the sampler
	task automatic tap(input logic ms, input logic di);
		jtag_pins.tms <= ms;
		jtag_pins.tdi <= di;
		jtag_pins.tck <= 1'b1;
		tick(5);
		jtag_pins.tck <= 1'b0;
		tick(5);
	endtask
	// Hang guard, counts as a mismatch
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 6000) begin
			errors++;
			wrap_up();
		end
	end
	initial begin
		logic [31:0] rd;
		hresetn <= 1'b0;
		hsel <= 1'b0;
		haddr <= 32'h0;
		htrans <= 2'h0;
		hwrite <= 1'b0;
		hsize <= 3'h2;
		hwdata <= 32'h0;
		// Only the enable pin high, muxed mode, no chip reset
		want <= cfg_pins_t'(15'h0200);
		jtag_pins <= 4'h1;
		enc_word_in <= {8{10'h155}};
		ser_word_in <= {8{10'h2AA}};
		dec_word_in <= {8{10'h0F0}};
		dec_fault_in <= 8'h00;
		tick(6);
		hresetn <= 1'b1;
		tick(1);
		chk("idle_rst", 1'b1, idle_delete_enable);
		chk("mode_rst", IF_MUXED, interface_mode);
		chk("lock_rst", 1'b0, pll_lock);
		rdchk("ctrl_rst", ADDR_CTRL, CTRL_RESET);
		rdchk("flags_rst", ADDR_FLAGS, FLAGS_RESET);
		foreach (rows[i]) begin
			bus(1'b1, ADDR_CTRL, rows[i].ctrl, rd);
			want.coding_pin <= rows[i].pin[2];
			want.violation_force_pin <= rows[i].pin[1];
			want.transfer_clock_select <= rows[i].pin[0];
			tick(5);
			chk("coding", rows[i].exp[2], coding_enable);
			chk("force", rows[i].exp[1], violation_force);
			chk("indep", rows[i].exp[0], independent_clock_mode);
			rdchk("ctrl", ADDR_CTRL, rows[i].ctrl & CTRL_WMASK);
		end
		bus(1'b1, ADDR_CTRL, 32'h0, rd);
		chk("lock_up", 1'b1, pll_lock);
		want.violation_force_pin <= 1'b1;
		dec_fault_in <= 8'h08;
		tick(5);
		chk("rx_plain", 10'h0F0, receive_word_out[3]);
		want.coding_pin <= 1'b1;
		tick(5);
		chk("rx_forced", VIOLATION_WORD, receive_word_out[3]);
		chk("rx_other", 10'h0F0, receive_word_out[0]);
		dec_fault_in <= 8'h00;
		rdchk("flags", ADDR_FLAGS, 32'h0000_0008);
		bus(1'b1, ADDR_FLAGS, 32'h0000_0008, rd);
		rdchk("flags_clr", ADDR_FLAGS, 32'h0);
		want.coding_pin <= 1'b0;
		want.violation_force_pin <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			want.mode <= m[1:0];
			tick(5);
			chk("mode", m, interface_mode);
		end
		rdchk("flags_mode", ADDR_FLAGS, 32'h0000_0100);
		want.mode <= 2'h0;
		for (int b = 0; b < 2; b++) begin
			want.busy_pass_enable <= b[0];
			tick(5);
			chk("idle_del", !b[0], idle_delete_enable);
		end
		want.serial_loopback <= 1'b1;
		tick(5);
		chk("feed_lp", 10'h155, dec_feed_out[0]);
		chk("tx_oe_lp", 1'b0, ser_tx_oe);
		want.serial_loopback <= 1'b0;
		tick(5);
		chk("feed", 10'h2AA, dec_feed_out[0]);
		chk("tx_oe", 1'b1, ser_tx_oe);
		chk("tx_data", 10'h155, ser_tx_out[0]);
		want.device_enable <= 1'b0;
		tick(5);
		chk("par_oe", 1'b0, par_oe);
		chk("tx_oe_off", 1'b0, ser_tx_oe);
		want.device_enable <= 1'b1;
		want.mgmt_phys_address_strap <= 5'h15;
		tick(4);
		want.chip_reset <= 1'b1;
		tick(6);
		chk("skew", 1'b1, skew_recenter);
		chk("fifo", 1'b1, fifo_recenter);
		chk("addr", 5'h15, mgmt_phys_address);
		rdchk("flags_cr", ADDR_FLAGS, 32'h0);
		want.mgmt_phys_address_strap <= 5'h0A;
		tick(5);
		chk("addr_hold", 5'h15, mgmt_phys_address);
		want.chip_reset <= 1'b0;
		tick(5);
		chk("skew_off", 1'b0, skew_recenter);
		want.power_down <= 1'b1;
		tick(5);
		chk("lock_pd", 1'b0, pll_lock);
		want.power_down <= 1'b0;
		tick(5);
		chk("lock_wait", 1'b0, pll_lock);
		tick(LW + 4);
		chk("lock_again", 1'b1, pll_lock);
		rdchk("status", ADDR_STATUS, ST_EXP);
		chk("tdo_idle", 1'b0, tdo_oe);
		tap(1'b0, 1'b0);
		tap(1'b1, 1'b0);
		tap(1'b0, 1'b0);
		tap(1'b0, 1'b0);
		chk("tdo_shift", 1'b1, tdo_oe);
		tap(1'b0, 1'b1);
		tap(1'b0, 1'b1);
		chk("tdo_data", 1'b1, tdo);
		jtag_pins.trst_n <= 1'b0;
		tick(5);
		chk("tdo_trst", 1'b0, tdo_oe);
		wrap_up();
	end
endmodule
`default_nettype wire
